/* src/sac_consts.svh */
// Register offsets, field positions, reset values and timing counts for the converter control.
// Assumes inclusion by the design files and the testbench by bare name.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
`define SAC_OFF_CTRL0     12'h000
`define SAC_OFF_CTRL1     12'h004
`define SAC_OFF_RES_HIGH  12'h008
`define SAC_OFF_RES_LOW   12'h00C
`define SAC_OFF_FLAGS     12'h010
`define SAC_OFF_IRQ_EN    12'h014
`define SAC_OFF_APIN_LO   12'h018
`define SAC_OFF_APIN_HI   12'h01C
`define SAC_OFF_SYS       12'h020
`define SAC_CTRL0_ON      0
`define SAC_CTRL0_GO      1
`define SAC_CTRL0_CHAN_LSB 2
`define SAC_CTRL0_CLK_LSB 6
`define SAC_CTRL1_VP      4
`define SAC_CTRL1_VN      5
`define SAC_CTRL1_JUST    7
`define SAC_APIN_LO_RST   8'hFF
`define SAC_APIN_HI_RST   8'h3F
`define SAC_APIN_HI_MASK  8'h3F
`define SAC_CONV_PERIODS  11
`define SAC_ABORT_PERIODS 2
`define SAC_DIV_FRC       8
`endif

/* src/sac_pkg.sv */
// Types shared by the converter control files.
// Assumes the constants header is on the include path.
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_CLK_DIV2,
    SAC_CLK_DIV8,
    SAC_CLK_DIV32,
    SAC_CLK_FRC
  } sac_clk_sel_t;
  typedef struct packed {
    logic [1:0] conv_clk_sel;
    logic [3:0] chan_sel;
    logic       go;
    logic       conv_on;
  } sac_ctrl0_t;
  typedef struct packed {
    logic       vref_neg_ext;
    logic       vref_pos_ext;
  } sac_vref_cfg_t;
endpackage : sac_pkg

/* src/sac_tick_gen.sv */
// Bit period tick generator: one-cycle enable per bit period.
// Assumes the system clock domain; the dedicated oscillator is modelled as a fixed divider.
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_tick_gen
  import sac_pkg::*;
#(
  parameter int FRC_DIV = `SAC_DIV_FRC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  logic [7:0] cnt_ff;
  logic [7:0] lim;

  always_comb begin
    case (sac_clk_sel_t'(sel_i))
      SAC_CLK_DIV2:  lim = 8'h01;
      SAC_CLK_DIV8:  lim = 8'h07;
      SAC_CLK_DIV32: lim = 8'h1F;
      SAC_CLK_FRC:   lim = 8'(FRC_DIV - 1);
      default:       lim = 8'h01;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !run_i || cnt_ff >= lim) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !run_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_ff >= lim);
    end
  end
endmodule : sac_tick_gen

/* src/sac_top.sv */
// Successive-approximation converter control with an AXI4-Lite register slave.
// Assumes a comparator input from the analog side, synchronised here; one 20 MHz clock.
//
// Function
// - Resolve ten result bits by successive approximation into the result pair.
// - Channel field picks the single input routed to the sample stage.
// - Positive and negative reference chosen independently.
// - Clock field picks divide by 2, 8, 32 or dedicated oscillator.
// - A full conversion lasts eleven bit periods.
// - Divided clock choices follow the system clock.
// - Done flag sets at every conversion end, irrespective of enable.
// - Interrupt raised while done flag and its enable are both set.
// - Hardware never clears the done flag; software does.
// - A conversion in sleep completes only on the dedicated oscillator; its interrupt wakes the device.
// - On wake, next instruction runs, then in-line or service routine.
// - Justify bit selects left or right result placement.
// - Enable converter first, then set go in a later write.
// - At conversion end clear go, set flag, write result.
// - Software abort keeps old result; acquisition restarts after two periods.
// - Codes 0..13 external inputs, 14 comparator ref, 15 fixed ref.
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_top
  import sac_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cmp_i,
  input  wire logic        sleep_i,
  input  wire logic        gie_i,
  output logic [3:0]       chan_sel_o,
  output logic             sample_o,
  output logic [9:0]       dac_code_o,
  output logic             vref_pos_ext_o,
  output logic             vref_neg_ext_o,
  output logic             conv_irq_o,
  output logic             wake_o,
  output logic             isr_branch_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ABORT} sac_state_t;
  sac_ctrl0_t    ctrl0_ff;
  sac_vref_cfg_t vref_cfg_ff;
  sac_state_t    state_ff;
  logic          result_justify_ff, conv_done_flag_ff, conv_irq_en_ff;
  logic [7:0]    result_high_ff, result_low_ff, analog_sel_low_ff;
  logic [5:0]    analog_sel_high_ff;
  logic [3:0]    per_ff;
  logic [9:0]    sar_ff, nxt_sar, trial_bit;
  logic          cmp_s1_ff, cmp_s2_ff, tick, done_evt, abort_evt, rd_ok;
  logic          aw_hold_ff, w_hold_ff, w_strb0_ff, wr_fire, wr_en, clr_flag, go_clr_sw;
  logic [11:0]   aw_addr_ff;
  logic [31:0]   w_data_ff, rd_val;

  sac_tick_gen sac_tick_gen_inst (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .run_i     (state_ff != ST_IDLE),
    .sel_i     (ctrl0_ff.conv_clk_sel),
    .tick_o    (tick)
  );

  // Comparator is analog-domain, two flops before use
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else begin
      cmp_s1_ff <= cmp_i;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // AXI write: address and data accepted independently
  assign wr_fire = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_hold_ff    <= 1'b0;
      w_hold_ff     <= 1'b0;
      aw_addr_ff    <= 12'h000;
      w_data_ff     <= 32'h0000_0000;
      w_strb0_ff    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_hold_ff && !s_axi_awready;
      s_axi_wready  <= !w_hold_ff && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff  <= 1'b1;
        w_data_ff  <= s_axi_wdata;
        w_strb0_ff <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign wr_en = wr_fire && w_strb0_ff;
  assign clr_flag = wr_en && aw_addr_ff == `SAC_OFF_FLAGS && w_data_ff[0];
  assign go_clr_sw = wr_en && aw_addr_ff == `SAC_OFF_CTRL0 && !w_data_ff[`SAC_CTRL0_GO];
  assign done_evt = state_ff == ST_CONV && tick && per_ff == 4'(`SAC_CONV_PERIODS - 1);
  assign abort_evt = state_ff == ST_CONV && (go_clr_sw || !ctrl0_ff.conv_on ||
                     (sleep_i && ctrl0_ff.conv_clk_sel != 2'b11));

  // Control fields; go set only if converter already on
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl0_ff <= '0;
    end else if (wr_en && aw_addr_ff == `SAC_OFF_CTRL0) begin
      ctrl0_ff.conv_clk_sel <= w_data_ff[`SAC_CTRL0_CLK_LSB +: 2];
      ctrl0_ff.chan_sel     <= w_data_ff[`SAC_CTRL0_CHAN_LSB +: 4];
      ctrl0_ff.conv_on      <= w_data_ff[`SAC_CTRL0_ON];
      ctrl0_ff.go <= w_data_ff[`SAC_CTRL0_GO] && ctrl0_ff.conv_on &&
                     state_ff != ST_ABORT && !done_evt && !abort_evt;
    end else if (done_evt || abort_evt) begin
      ctrl0_ff.go <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vref_cfg_ff       <= '0;
      result_justify_ff <= 1'b0;
      conv_irq_en_ff    <= 1'b0;
      analog_sel_low_ff  <= `SAC_APIN_LO_RST;
      analog_sel_high_ff <= 6'(`SAC_APIN_HI_RST);
    end else if (wr_en) begin
      case (aw_addr_ff)
        `SAC_OFF_CTRL1: begin
          vref_cfg_ff.vref_pos_ext <= w_data_ff[`SAC_CTRL1_VP];
          vref_cfg_ff.vref_neg_ext <= w_data_ff[`SAC_CTRL1_VN];
          result_justify_ff        <= w_data_ff[`SAC_CTRL1_JUST];
        end
        `SAC_OFF_IRQ_EN:   conv_irq_en_ff     <= w_data_ff[0];
        `SAC_OFF_APIN_LO: analog_sel_low_ff  <= w_data_ff[7:0];
        `SAC_OFF_APIN_HI: analog_sel_high_ff <= w_data_ff[5:0];
        default: ;
      endcase
    end
  end

  // Conversion sequencer: one period that loads the first trial code, then ten bit decisions
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      per_ff   <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          per_ff <= 4'h0;
          if (ctrl0_ff.go && ctrl0_ff.conv_on) state_ff <= ST_CONV;
        end
        ST_CONV: begin
          if (abort_evt) begin
            state_ff <= ST_ABORT;
            per_ff   <= 4'h0;
          end else if (done_evt) begin
            state_ff <= ST_IDLE;
          end else if (tick) begin
            per_ff <= per_ff + 4'h1;
          end
        end
        ST_ABORT: begin
          if (tick && per_ff == 4'(`SAC_ABORT_PERIODS - 1)) begin
            state_ff <= ST_IDLE;
          end else if (tick) begin
            per_ff <= per_ff + 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    trial_bit = 10'h200 >> (per_ff - 4'h1);
    nxt_sar   = sar_ff;
    if (per_ff == 4'h0) begin
      nxt_sar = 10'h200;
    end else begin
      if (!cmp_s2_ff) nxt_sar = sar_ff & ~trial_bit;
      if (per_ff < 4'(`SAC_CONV_PERIODS - 1)) nxt_sar = nxt_sar | (trial_bit >> 1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sar_ff <= 10'h000;
    end else if (state_ff == ST_CONV && tick) begin
      sar_ff <= nxt_sar;
    end
  end

  // Result only written on normal completion
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      result_high_ff <= 8'h00;
      result_low_ff  <= 8'h00;
    end else if (done_evt) begin
      if (result_justify_ff) begin
        result_high_ff <= {6'h00, nxt_sar[9:8]};
        result_low_ff  <= nxt_sar[7:0];
      end else begin
        result_high_ff <= nxt_sar[9:2];
        result_low_ff  <= {nxt_sar[1:0], 6'h00};
      end
    end
  end

  // Set wins over a same-cycle software clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      conv_done_flag_ff <= 1'b0;
    end else if (done_evt) begin
      conv_done_flag_ff <= 1'b1;
    end else if (clr_flag) begin
      conv_done_flag_ff <= 1'b0;
    end
  end

  // Pin-facing outputs, all registered
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      chan_sel_o     <= 4'h0;
      sample_o       <= 1'b0;
      dac_code_o     <= 10'h000;
      vref_pos_ext_o <= 1'b0;
      vref_neg_ext_o <= 1'b0;
      conv_irq_o     <= 1'b0;
      wake_o         <= 1'b0;
      isr_branch_o   <= 1'b0;
    end else begin
      chan_sel_o     <= ctrl0_ff.chan_sel;
      sample_o       <= ctrl0_ff.conv_on && (state_ff == ST_IDLE);
      dac_code_o     <= sar_ff;
      vref_pos_ext_o <= vref_cfg_ff.vref_pos_ext;
      vref_neg_ext_o <= vref_cfg_ff.vref_neg_ext;
      conv_irq_o     <= conv_done_flag_ff && conv_irq_en_ff;
      wake_o         <= sleep_i && conv_done_flag_ff && conv_irq_en_ff;
      isr_branch_o   <= conv_done_flag_ff && conv_irq_en_ff && gie_i;
    end
  end

  // AXI read, one cycle after address acceptance
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `SAC_OFF_CTRL0:    rd_val = {24'h00_0000, ctrl0_ff};
      `SAC_OFF_CTRL1:    rd_val = {24'h00_0000, result_justify_ff, 1'b0, vref_cfg_ff, 4'h0};
      `SAC_OFF_RES_HIGH: rd_val = {24'h00_0000, result_high_ff};
      `SAC_OFF_RES_LOW:  rd_val = {24'h00_0000, result_low_ff};
      `SAC_OFF_FLAGS:    rd_val = {31'h0000_0000, conv_done_flag_ff};
      `SAC_OFF_IRQ_EN:   rd_val = {31'h0000_0000, conv_irq_en_ff};
      `SAC_OFF_APIN_LO:  rd_val = {24'h00_0000, analog_sel_low_ff};
      `SAC_OFF_APIN_HI:  rd_val = {26'h000_0000, analog_sel_high_ff};
      `SAC_OFF_SYS:      rd_val = {28'h000_0000, state_ff == ST_ABORT, state_ff == ST_CONV,
                                   sleep_i, gie_i};
      default:           rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  AST_DONE_CLEARS_GO: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    done_evt |=> !ctrl0_ff.go && conv_done_flag_ff)
    else $error("go not cleared or flag not set at conversion end");
  AST_FLAG_STICKY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    conv_done_flag_ff && !clr_flag |=> conv_done_flag_ff)
    else $error("done flag dropped without software clear");
  AST_IRQ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    conv_done_flag_ff && conv_irq_en_ff |=> conv_irq_o)
    else $error("interrupt missing");
  AST_ABORT_KEEPS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_ff == ST_ABORT |=> $stable(result_high_ff) && $stable(result_low_ff))
    else $error("result changed after abort");
  AST_LEFT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    done_evt && !result_justify_ff |=> result_low_ff[5:0] == 6'h00)
    else $error("left format low bits not zero");
  AST_RIGHT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    done_evt && result_justify_ff |=> result_high_ff[7:2] == 6'h00)
    else $error("right format high bits not zero");
  AST_WAKE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sleep_i && conv_done_flag_ff && conv_irq_en_ff |=> wake_o)
    else $error("no wake from sleep");
  AST_CHAN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> chan_sel_o == $past(ctrl0_ff.chan_sel))
    else $error("channel output mismatch");
endmodule : sac_top

/* tb/sac_analog_model.sv */
// Analog side model: per-channel input level compared with the trial code.
// Assumes the design synchronises cmp_o; slow mode adds one clock of comparator lag.
`timescale 1ns/1ps
module sac_analog_model (
  input  wire logic       sys_clk_i,
  input  wire logic       slow_i,
  input  wire logic [3:0] chan_sel_i,
  input  wire logic [9:0] dac_code_i,
  output logic            cmp_o
);
  logic [9:0] level;
  logic       cmp_now;
  logic       cmp_ff;
  // Each selected input shows its own fixed level
  assign level   = {6'h00, chan_sel_i} * 10'h043 + 10'h005;
  assign cmp_now = (level >= dac_code_i);
  always_ff @(posedge sys_clk_i) begin
    cmp_ff <= cmp_now;
  end
  // Lag only safe with long bit periods
  assign cmp_o = slow_i ? cmp_ff : cmp_now;
endmodule : sac_analog_model

/* tb/sar_adc_control_test.sv */
// Testbench for the converter control: register bus tasks and conversion scenarios.
// Assumes the analog model on the comparator side and a 20 MHz clock.
`timescale 1ns/1ps
`include "sac_consts.svh"
module sar_adc_control_test;
  import sac_pkg::*;
  logic        sys_clk_i, rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, cmp_i, sleep_i, gie_i, slow_i, sample_o, vref_pos_ext_o;
  logic        vref_neg_ext_o, conv_irq_o, wake_o, isr_branch_o;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, chan_sel_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
  logic [9:0]  dac_code_o, r;
  int          errors, cmp_count, cyc, dur, p;

  sac_top sac_top_inst (.sys_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmp_i, .sleep_i, .gie_i, .chan_sel_o, .sample_o,
    .dac_code_o, .vref_pos_ext_o, .vref_neg_ext_o, .conv_irq_o, .wake_o, .isr_branch_o);
  sac_analog_model sac_analog_model_inst (.sys_clk_i, .slow_i, .chan_sel_i(chan_sel_o),
    .dac_code_i(dac_code_o), .cmp_o(cmp_i));

  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang;
    errors++;
    $display("[FAIL] %0t wait bound used up", $time);
    results();
  endtask : hang

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    bit b;
    int n;
    aw = 0;
    w = 0;
    b = 0;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!b) begin
      @(posedge sys_clk_i);
      if (n++ > 100) hang();
      if (aw && w && s_axi_bvalid === 1'b1) begin
        b = 1;
        br = s_axi_bresp;
      end
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask : wr

  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] e);
    bit ar;
    int n;
    ar = 0;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (n++ > 100) hang();
      if (ar && s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        e = s_axi_rresp;
        break;
      end
      if (!ar && s_axi_arready === 1'b1) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask : rdr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rdr(a, rd, rr);
    chk(rd, exp);
  endtask : rchk

  function automatic logic [31:0] c0w(input logic [1:0] ck, input logic [3:0] ch, input logic go);
    sac_ctrl0_t c;
    c = '{conv_clk_sel: ck, chan_sel: ch, go: go, conv_on: 1'b1};
    return {24'h00_0000, c};
  endfunction : c0w

  // Cycle count from go accepted until go reads back clear
  task automatic convert(input logic [1:0] ck, input logic [3:0] ch);
    int n;
    int t0;
    n = 0;
    wr(`SAC_OFF_CTRL0, c0w(ck, ch, 1'b0));
    repeat (40) @(posedge sys_clk_i);
    wr(`SAC_OFF_CTRL0, c0w(ck, ch, 1'b1));
    t0 = cyc;
    do begin
      rdr(`SAC_OFF_CTRL0, rd, rr);
      if (n++ > 400) hang();
    end while (rd[1] !== 1'b0);
    dur = cyc - t0;
  endtask : convert

  initial begin
    {sys_clk_i, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sleep_i, gie_i, slow_i} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, errors, cmp_count, cyc} = '0;
    {rst_i, s_axi_bready, s_axi_rready} = 3'h7;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rchk(`SAC_OFF_CTRL0, 32'h0000_0000);
    rchk(`SAC_OFF_CTRL1, 32'h0000_0000);
    rchk(`SAC_OFF_FLAGS, 32'h0000_0000);
    rchk(`SAC_OFF_APIN_LO, 32'h0000_00FF);
    rchk(`SAC_OFF_APIN_HI, 32'h0000_003F);
    wr(`SAC_OFF_APIN_HI, 32'h0000_00FF);
    rchk(`SAC_OFF_APIN_HI, 32'h0000_003F);
    rdr(12'h0FC, rd, rr);
    chk(rr, 2'b10);
    wr(`SAC_OFF_CTRL0, 32'h0000_0002);
    rchk(`SAC_OFF_CTRL0, 32'h0000_0000);
    chk(br, 2'b00);
    for (int i = 0; i < 4; i++) begin
      wr(`SAC_OFF_CTRL1, {26'h000_0000, i[1:0], 4'h0});
      repeat (2) @(posedge sys_clk_i);
      chk(vref_pos_ext_o, i[0]);
      chk(vref_neg_ext_o, i[1]);
    end
    for (int c = 0; c < 16; c++) begin
      wr(`SAC_OFF_CTRL0, c0w(2'b00, c[3:0], 1'b0));
      repeat (2) @(posedge sys_clk_i);
      chk(chan_sel_o, c[3:0]);
    end
    for (int k = 0; k < 4; k++) begin
      wr(`SAC_OFF_CTRL1, {24'h00_0000, k[0], 7'h00});
      wr(`SAC_OFF_FLAGS, 32'h0000_0001);
      slow_i <= (k == 2);
      convert(k[1] ? 2'b10 : 2'b01, 4'(k * 4 + 1));
      p = k[1] ? 32 : 8;
      chk(dur >= 10 * p && dur <= 12 * p + 16, 1'b1);
      r = 10'(k * 4 + 1) * 10'h043 + 10'h005;
      rchk(`SAC_OFF_FLAGS, 32'h0000_0001);
      chk(conv_irq_o, 1'b0);
      rchk(`SAC_OFF_RES_HIGH, k[0] ? {30'h0000_0000, r[9:8]} : {24'h00_0000, r[9:2]});
      rchk(`SAC_OFF_RES_LOW, k[0] ? {24'h00_0000, r[7:0]} : {24'h00_0000, r[1:0], 6'h00});
    end
    slow_i <= 1'b0;
    // Divide by 2 is shorter than the comparator path; timing and the done flag are checked, not the result
    wr(`SAC_OFF_FLAGS, 32'h0000_0001);
    convert(2'b00, 4'd2);
    chk(dur >= 20 && dur <= 40, 1'b1);
    rchk(`SAC_OFF_FLAGS, 32'h0000_0001);
    repeat (50) @(posedge sys_clk_i);
    rchk(`SAC_OFF_FLAGS, 32'h0000_0001);
    wr(`SAC_OFF_FLAGS, 32'h0000_0001);
    rchk(`SAC_OFF_FLAGS, 32'h0000_0000);
    wr(`SAC_OFF_IRQ_EN, 32'h0000_0001);
    gie_i   <= 1'b1;
    sleep_i <= 1'b1;
    convert(2'b11, 4'd7);
    chk(dur >= 80 && dur <= 112, 1'b1);
    repeat (2) @(posedge sys_clk_i);
    chk(conv_irq_o, 1'b1);
    chk(wake_o, 1'b1);
    chk(isr_branch_o, 1'b1);
    rchk(`SAC_OFF_SYS, 32'h0000_0003);
    gie_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk(isr_branch_o, 1'b0);
    wr(`SAC_OFF_FLAGS, 32'h0000_0001);
    sleep_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk(conv_irq_o, 1'b0);
    r = 10'd7 * 10'h043 + 10'h005;
    rchk(`SAC_OFF_RES_LOW, {24'h00_0000, r[7:0]});
    wr(`SAC_OFF_CTRL0, c0w(2'b10, 4'd3, 1'b1));
    repeat (100) @(posedge sys_clk_i);
    wr(`SAC_OFF_CTRL0, c0w(2'b10, 4'd3, 1'b0));
    repeat (2) @(posedge sys_clk_i);
    chk(sample_o, 1'b0);
    rchk(`SAC_OFF_SYS, 32'h0000_0008);
    repeat (80) @(posedge sys_clk_i);
    chk(sample_o, 1'b1);
    rchk(`SAC_OFF_FLAGS, 32'h0000_0000);
    rchk(`SAC_OFF_RES_LOW, {24'h00_0000, r[7:0]});
    wr(`SAC_OFF_CTRL0, c0w(2'b10, 4'd3, 1'b1));
    repeat (50) @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rchk(`SAC_OFF_CTRL0, 32'h0000_0000);
    chk(chan_sel_o, 4'h0);
    results();
  end
endmodule : sar_adc_control_test
